// ===== pkg/lcc_pkg.sv
`default_nettype none
package lcc_pkg;
	localparam int DATA_W       = 8;
	localparam int PTR_W        = 7;
	localparam int VREG_W       = 6;
	localparam int DISP_DEPTH   = 128;
	localparam int GLYPH_DEPTH  = 64;
	localparam int BUF_DEPTH    = 2;
	localparam int VIS_CHARS    = 24;
	localparam int POR_CYC      = 3;
	localparam int FRAME_DIV    = 3072;
	localparam int CLK_PERIOD_NS = 10;
	localparam int EXEC_NS      = 400;
	localparam int EXEC_CYC     = (EXEC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam logic [6:0] A_BASE     = 7'h00;
	localparam logic [6:0] A_END_1X24 = 7'h4F;
	localparam logic [6:0] A_L1_END   = 7'h27;
	localparam logic [6:0] A_L2_BASE  = 7'h40;
	localparam logic [6:0] A_L2_END   = 7'h67;
	localparam logic [6:0] LEN_1X24   = 7'h50;
	localparam logic [6:0] LEN_LINE   = 7'h28;

	localparam logic [12:0] V_STEP_MV = 13'h0050;
	localparam logic [12:0] V_OFS_MV  = 13'h071C;
	localparam logic [2:0]  BIAS_MUX2 = 3'h4;
	localparam logic [2:0]  BIAS_FULL = 3'h5;
	localparam logic [VREG_W-1:0] VREG_RST = 6'h00;

	// Instruction field positions
	localparam int OP_SETD_BIT  = 7;
	localparam int CF_MODE_HI   = 4;
	localparam int CF_MODE_LO   = 3;
	localparam int CF_ICON_BIT  = 2;
	localparam int CF_DEC_BIT   = 1;
	localparam int CF_EXT_BIT   = 0;
	localparam int SH_DIR_BIT   = 3;
	localparam int VS_SEL_BIT   = 6;
	localparam int BYP_BIT      = 0;

	typedef enum logic [1:0] {MODE_1X24, MODE_2X12, MODE_1X12} lcc_mode_e;
endpackage
`default_nettype wire

// ===== rtl/lcc_host_core.sv
// Behaviour
// RL1: Separate six-bit supply settings for character mode and icon mode.
// RL2: Nominal supply equals setting times 80 mV plus 1820 mV.
// RL3: Zero in the active mode's setting turns the generator off.
// RL4: Host keeps settings between 2.2 V and 6.5 V.
// RL5: Bypass bit stops generator and ties supply output to second rail.
// RL6: Icon mode (1:2) uses four bias levels, other rates five.
// RL7: Frame tick comes from clock divided by 3072.
// RL8: Host stops the clock only in power-down.
// RL9: Reset completes internally within three clock cycles.
// RL10: Select line picks eight-bit instruction or data register.
// RL11: Instruction register is write only, never read back.
// RL12: RAM byte at pointer is prefetched into holding register for reads.
// RL13: Busy flag high while working; instructions then ignored.
// RL14: Status read drives busy flag on top bus bit.
// RL15: Status read drives pointer on the lower seven bits.
// RL16: Host writes instructions only after busy reads zero.
// RL17: Address commands load pointer; each RAM access steps it by one.
// RL18: Display RAM holds 80 codes; unshown cells stay usable.
// RL19: Unshifted line one shows the 24 codes from address 00h.
// RL20: Address space per mode: 00-4F, 00-27 plus 40-67, 00-27.
// RL21: Access stepping wraps to next line per mode.
// RL22: Display shift wraps each line within itself, all together.
`timescale 1ns/100ps
`default_nettype none
module lcc_host_core import lcc_pkg::*; #(
	parameter int EXEC_CYCLES  = EXEC_CYC,
	parameter int FRAME_DIVIDE = FRAME_DIV
) (
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              bus_strobe,
	input  wire logic              register_choice_line,
	input  wire logic              read_not_write,
	input  wire logic [DATA_W-1:0] db_in,
	output logic      [DATA_W-1:0] db_out,
	output logic      [DATA_W-1:0] db_oe,
	output logic                   busy_flag,
	input  wire logic              scan_req,
	input  wire logic              scan_line,
	input  wire logic [4:0]        scan_idx,
	output logic      [PTR_W-1:0]  scan_addr,
	output logic      [DATA_W-1:0] scan_code,
	output logic                   frame_tick,
	output logic                   gen_enable,
	output logic                   supply_bypass_select,
	output logic      [VREG_W-1:0] vlcd_code,
	output logic      [12:0]       vlcd_nom_mv,
	output logic      [2:0]        bias_levels
);
	localparam int PIN_W = DATA_W + 3;
	localparam int EXW   = $clog2(EXEC_CYCLES + 1);
	localparam int FDW   = $clog2(FRAME_DIVIDE);
	localparam int BPW   = $clog2(BUF_DEPTH);

	logic [PIN_W-1:0]  pin_s1_reg;
	logic [PIN_W-1:0]  pin_s2_reg;
	logic              strobe_d_reg;
	logic [1:0]        por_cnt_reg;
	logic [EXW-1:0]    exec_cnt_reg;
	logic [PTR_W-1:0]  ram_pointer_reg;
	logic              space_glyph_reg;
	lcc_mode_e         mode_reg;
	logic              icon_reg;
	logic              dec_reg;
	logic              ext_reg;
	logic [PTR_W-1:0]  shift_reg;
	logic [VREG_W-1:0] character_mode_voltage_setting_reg;
	logic [VREG_W-1:0] icon_mode_voltage_setting_reg;
	logic              bypass_reg;
	logic [DATA_W-1:0] ram_transfer_holding_reg;
	logic              fetch_pend_reg;
	logic [DATA_W-1:0] buf_mem [BUF_DEPTH];
	logic [BPW-1:0]    buf_wr_reg;
	logic [BPW-1:0]    buf_rd_reg;
	logic [BPW:0]      buf_cnt_reg;
	logic [DATA_W-1:0] disp_mem [DISP_DEPTH];
	logic [DATA_W-1:0] glyph_mem [GLYPH_DEPTH];
	logic [FDW-1:0]    frame_cnt_reg;
	logic              frame_tick_reg;
	logic [DATA_W-1:0] db_out_reg;
	logic [PTR_W-1:0]  scan_addr_reg;
	logic [DATA_W-1:0] scan_code_reg;
	logic              gen_enable_reg;
	logic [VREG_W-1:0] vlcd_code_reg;
	logic [12:0]       vlcd_mv_reg;
	logic [2:0]        bias_reg;

	logic              strobe_s;
	logic              sel_data;
	logic              rd_s;
	logic [DATA_W-1:0] db_s;
	logic              strobe_fall;
	logic              por_busy;
	logic              busy;
	logic              instr_we;
	logic              data_push;
	logic              data_read;
	logic              buf_in_ready;
	logic              buf_out_valid;
	logic              buf_pop;
	logic [DATA_W-1:0] buf_head;
	logic [PTR_W-1:0]  line_len;
	logic [PTR_W-1:0]  scan_sum;
	logic [PTR_W-1:0]  scan_off;
	logic [PTR_W-1:0]  scan_addr_c;
	logic [VREG_W-1:0] active_code;

	// Walks the pointer one step, wrapping to the next line of the current mode
	function automatic logic [PTR_W-1:0] step_addr(input logic [PTR_W-1:0] a,
		input logic glyph, input logic dn, input lcc_mode_e m);
		logic [PTR_W-1:0] r;
		r = dn ? a - 7'h01 : a + 7'h01;
		if (glyph) begin
			r = {1'b0, r[5:0]};
		end else begin
			unique case (m)
				MODE_1X24: begin
					if (!dn && a == A_END_1X24)
						r = A_BASE;
					else if (dn && a == A_BASE)
						r = A_END_1X24;
				end
				MODE_2X12: begin
					if (!dn && a == A_L1_END)
						r = A_L2_BASE;
					else if (!dn && a == A_L2_END)
						r = A_BASE;
					else if (dn && a == A_L2_BASE)
						r = A_L1_END;
					else if (dn && a == A_BASE)
						r = A_L2_END;
				end
				MODE_1X12: begin
					if (!dn && a == A_L1_END)
						r = A_BASE;
					else if (dn && a == A_BASE)
						r = A_L1_END;
				end
			endcase
		end
		return r;
	endfunction

	// Pins come from the host's domain, so two stages before any use
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pin_s1_reg   <= '0;
			pin_s2_reg   <= '0;
			strobe_d_reg <= 1'b0;
		end else begin
			pin_s1_reg   <= {bus_strobe, register_choice_line, read_not_write, db_in};
			pin_s2_reg   <= pin_s1_reg;
			strobe_d_reg <= pin_s2_reg[PIN_W-1];
		end
	end

	assign strobe_s    = pin_s2_reg[PIN_W-1];
	assign sel_data    = pin_s2_reg[PIN_W-2];
	assign rd_s        = pin_s2_reg[PIN_W-3];
	assign db_s        = pin_s2_reg[DATA_W-1:0];
	assign strobe_fall = strobe_d_reg & ~strobe_s;

	// RL9 three-cycle init
	always_ff @(posedge mclk) begin
		if (!rst_n)
			por_cnt_reg <= '0;
		else if (por_busy)
			por_cnt_reg <= por_cnt_reg + 2'h1;
	end
	assign por_busy = por_cnt_reg != 2'(POR_CYC);

	// RL13 busy gating; pending buffer or prefetch also holds the host off
	assign busy      = por_busy | (exec_cnt_reg != '0) | (buf_cnt_reg != '0) | fetch_pend_reg;
	assign busy_flag = busy;
	assign instr_we  = strobe_fall & ~sel_data & ~rd_s & ~busy;
	// RL10 select line routes the access
	assign data_push = strobe_fall & sel_data & ~rd_s;
	assign data_read = strobe_fall & sel_data & rd_s & ~busy;

	always_ff @(posedge mclk) begin
		if (!rst_n || por_busy)
			exec_cnt_reg <= '0;
		else if (instr_we)
			exec_cnt_reg <= EXW'(EXEC_CYCLES);
		else if (exec_cnt_reg != '0)
			exec_cnt_reg <= exec_cnt_reg - EXW'(1);
	end

	// Write buffer: a full buffer refuses the byte, which the busy flag warns of
	assign buf_in_ready  = buf_cnt_reg != (BPW+1)'(BUF_DEPTH);
	assign buf_out_valid = buf_cnt_reg != '0;
	// Display scan owns the RAM port, so draining stalls behind it
	assign buf_pop  = buf_out_valid & ~scan_req;
	assign buf_head = buf_mem[buf_rd_reg];

	always_ff @(posedge mclk) begin
		if (!rst_n || por_busy) begin
			buf_wr_reg  <= '0;
			buf_rd_reg  <= '0;
			buf_cnt_reg <= '0;
		end else begin
			if (data_push && buf_in_ready) begin
				buf_mem[buf_wr_reg] <= db_s;
				buf_wr_reg          <= buf_wr_reg + 1'b1;
			end
			if (buf_pop)
				buf_rd_reg <= buf_rd_reg + 1'b1;
			buf_cnt_reg <= buf_cnt_reg + (BPW+1)'(data_push && buf_in_ready)
				- (BPW+1)'(buf_pop);
		end
	end

	// RL17 pointer load and step
	always_ff @(posedge mclk) begin
		if (!rst_n || por_busy) begin
			ram_pointer_reg <= '0;
			space_glyph_reg <= 1'b0;
		end else if (instr_we && !ext_reg && db_s[OP_SETD_BIT]) begin
			ram_pointer_reg <= db_s[PTR_W-1:0];
			space_glyph_reg <= 1'b0;
		end else if (instr_we && !ext_reg && db_s[7:6] == 2'h1) begin
			ram_pointer_reg <= {1'b0, db_s[5:0]};
			space_glyph_reg <= 1'b1;
		end else if (data_read || buf_pop) begin
			// RL21 wrap on access
			ram_pointer_reg <= step_addr(ram_pointer_reg, space_glyph_reg, dec_reg, mode_reg);
		end
	end

	// RL18 RAM writes; cells outside the shown window are plain storage
	always_ff @(posedge mclk) begin
		if (buf_pop && !space_glyph_reg)
			disp_mem[ram_pointer_reg] <= buf_head;
		if (buf_pop && space_glyph_reg)
			glyph_mem[ram_pointer_reg[5:0]] <= buf_head;
	end

	// RL12 refill holding after every address change
	always_ff @(posedge mclk) begin
		if (!rst_n || por_busy) begin
			fetch_pend_reg           <= 1'b0;
			ram_transfer_holding_reg <= '0;
		end else if (instr_we && !ext_reg && db_s[7:6] != 2'h0) begin
			fetch_pend_reg <= 1'b1;
		end else if (data_read || buf_pop) begin
			fetch_pend_reg <= 1'b1;
		end else if (fetch_pend_reg && !buf_out_valid && !scan_req) begin
			fetch_pend_reg           <= 1'b0;
			ram_transfer_holding_reg <= space_glyph_reg ?
				glyph_mem[ram_pointer_reg[5:0]] : disp_mem[ram_pointer_reg];
		end
	end

	// Mode, icon, direction and page bits
	always_ff @(posedge mclk) begin
		if (!rst_n || por_busy) begin
			mode_reg <= MODE_1X24;
			icon_reg <= 1'b0;
			dec_reg  <= 1'b0;
			ext_reg  <= 1'b0;
		end else if (instr_we && db_s[7:5] == 3'h1) begin
			unique case (db_s[CF_MODE_HI:CF_MODE_LO])
				2'h1:    mode_reg <= MODE_2X12;
				2'h2:    mode_reg <= MODE_1X12;
				default: mode_reg <= MODE_1X24;
			endcase
			icon_reg <= db_s[CF_ICON_BIT];
			dec_reg  <= db_s[CF_DEC_BIT];
			ext_reg  <= db_s[CF_EXT_BIT];
		end
	end

	// RL1 supply registers and RL5 bypass, reached through the extended page
	always_ff @(posedge mclk) begin
		if (!rst_n || por_busy) begin
			character_mode_voltage_setting_reg <= VREG_RST;
			icon_mode_voltage_setting_reg      <= VREG_RST;
			bypass_reg                         <= 1'b0;
		end else if (instr_we && ext_reg) begin
			if (db_s[7] && !db_s[VS_SEL_BIT])
				character_mode_voltage_setting_reg <= db_s[VREG_W-1:0];
			else if (db_s[7] && db_s[VS_SEL_BIT])
				icon_mode_voltage_setting_reg <= db_s[VREG_W-1:0];
			else if (db_s[7:6] == 2'h1)
				bypass_reg <= db_s[BYP_BIT];
		end
	end

	assign line_len = (mode_reg == MODE_1X24) ? LEN_1X24 : LEN_LINE;

	// RL22 shift offset shared by all lines; a mode change re-homes it
	always_ff @(posedge mclk) begin
		if (!rst_n || por_busy) begin
			shift_reg <= '0;
		end else if (instr_we && db_s[7:5] == 3'h1) begin
			shift_reg <= '0;
		end else if (instr_we && !ext_reg && db_s[7:4] == 4'h1) begin
			if (db_s[SH_DIR_BIT])
				shift_reg <= (shift_reg == '0) ? line_len - 7'h01 : shift_reg - 7'h01;
			else
				shift_reg <= (shift_reg == line_len - 7'h01) ? '0 : shift_reg + 7'h01;
		end
	end

	// RL19 line one starts at 00h; RL20 line two of two-line mode at 40h
	assign scan_sum    = shift_reg + {2'h0, scan_idx};
	assign scan_off    = (scan_sum >= line_len) ? scan_sum - line_len : scan_sum;
	assign scan_addr_c = ((mode_reg == MODE_2X12) && scan_line) ?
		A_L2_BASE + scan_off : A_BASE + scan_off;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			scan_addr_reg <= '0;
			scan_code_reg <= '0;
		end else if (scan_req) begin
			scan_addr_reg <= scan_addr_c;
			scan_code_reg <= disp_mem[scan_addr_c];
		end
	end

	// RL7 frame divider
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			frame_cnt_reg  <= '0;
			frame_tick_reg <= 1'b0;
		end else begin
			frame_tick_reg <= frame_cnt_reg == FDW'(FRAME_DIVIDE - 1);
			if (frame_cnt_reg == FDW'(FRAME_DIVIDE - 1))
				frame_cnt_reg <= '0;
			else
				frame_cnt_reg <= frame_cnt_reg + FDW'(1);
		end
	end

	assign active_code = icon_reg ? icon_mode_voltage_setting_reg
		: character_mode_voltage_setting_reg;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			gen_enable_reg <= 1'b0;
			vlcd_code_reg  <= '0;
			vlcd_mv_reg    <= '0;
			bias_reg       <= BIAS_FULL;
		end else begin
			// RL3 zero code stops the generator; RL5 bypass overrides
			gen_enable_reg <= (active_code != '0) && !bypass_reg;
			vlcd_code_reg  <= active_code;
			// RL2 nominal level in millivolts
			vlcd_mv_reg    <= ((active_code != '0) && !bypass_reg) ?
				13'(active_code) * V_STEP_MV + V_OFS_MV : '0;
			// RL6 bias follows multiplex rate
			bias_reg       <= icon_reg ? BIAS_MUX2 : BIAS_FULL;
		end
	end

	// RL14 busy on top bit, RL15 pointer below; RL11 instruction never returned
	always_ff @(posedge mclk) begin
		if (!rst_n)
			db_out_reg <= '0;
		else
			db_out_reg <= sel_data ? ram_transfer_holding_reg : {busy, ram_pointer_reg};
	end

	assign db_out               = db_out_reg;
	assign db_oe                = {DATA_W{strobe_s & rd_s}};
	assign scan_addr            = scan_addr_reg;
	assign scan_code            = scan_code_reg;
	assign frame_tick           = frame_tick_reg;
	assign gen_enable           = gen_enable_reg;
	assign supply_bypass_select = bypass_reg;
	assign vlcd_code            = vlcd_code_reg;
	assign vlcd_nom_mv          = vlcd_mv_reg;
	assign bias_levels          = bias_reg;
endmodule
`default_nettype wire

// ===== verif/lcc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_host_model import lcc_pkg::*; (
	input  wire logic              mclk,
	input  wire logic [DATA_W-1:0] db_out,
	input  wire logic [DATA_W-1:0] db_oe,
	output logic                   bus_strobe,
	output logic                   register_choice_line,
	output logic                   read_not_write,
	output logic      [DATA_W-1:0] db_in
);
	logic [DATA_W-1:0] drv = 8'h00;
	assign db_in = (db_oe & db_out) | (~db_oe & drv);
	initial begin
		bus_strobe = 1'b0;
		register_choice_line = 1'b0;
		read_not_write = 1'b1;
	end
	task automatic access(input logic sel, input logic rnw, input logic [DATA_W-1:0] wd,
		output logic [DATA_W-1:0] rd);
		@(negedge mclk);
		register_choice_line = sel;
		read_not_write = rnw;
		drv = wd;
		repeat (2) @(negedge mclk);
		bus_strobe = 1'b1;
		repeat (6) @(negedge mclk);
		rd = db_in;
		bus_strobe = 1'b0;
		repeat (5) @(negedge mclk);
		// Released lines flip so stale data never looks valid
		drv = ~wd;
		read_not_write = 1'b1;
	endtask
	task automatic wait_idle();
		logic [DATA_W-1:0] st;
		st = 8'h80;
		repeat (6) @(negedge mclk);
		for (int i = 0; i < 40 && st[7] !== 1'b0; i++) begin
			access(1'b0, 1'b1, 8'h00, st);
		end
	endtask
	task automatic instr(input logic [DATA_W-1:0] code);
		logic [DATA_W-1:0] st;
		wait_idle();
		access(1'b0, 1'b0, code, st);
	endtask
endmodule
`default_nettype wire

// ===== verif/lcc_host_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lcc_host_monitor import lcc_pkg::*; #(
	parameter int FRAME_DIVIDE = FRAME_DIV
) (
	input wire logic              mclk,
	input wire logic              rst_n,
	input wire logic              bus_strobe,
	input wire logic              read_not_write,
	input wire logic [DATA_W-1:0] db_oe,
	input wire logic              busy_flag,
	input wire logic              frame_tick,
	input wire logic              gen_enable,
	input wire logic              supply_bypass_select,
	input wire logic [VREG_W-1:0] vlcd_code,
	input wire logic [12:0]       vlcd_nom_mv,
	input wire logic [2:0]        bias_levels
);
	int   cnt;
	logic seen;
	always_ff @(posedge mclk) begin
		cnt <= (!rst_n || frame_tick) ? 0 : cnt + 1;
	end
	// First tick after reset has no known phase
	always_ff @(posedge mclk) begin
		seen <= rst_n && (seen || frame_tick);
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_init_busy;
		$rose(rst_n) |-> busy_flag [*3];
	endproperty
	a_init_busy: assert property (p_init_busy) else $error("busy low in init");
	// Pin lag of two or three edges through the synchronisers
	property p_oe_on;
		$past(bus_strobe, 2) && $past(bus_strobe, 3) && $past(read_not_write, 2)
			&& $past(read_not_write, 3) |-> db_oe == 8'hFF;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("bus not driven on read");
	property p_oe_off;
		!$past(bus_strobe, 2) && !$past(bus_strobe, 3) |-> db_oe == 8'h00;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven while idle");
	property p_nom;
		gen_enable |-> vlcd_nom_mv == 13'h0050 * vlcd_code + 13'h071C;
	endproperty
	a_nom: assert property (p_nom) else $error("nominal supply wrong");
	property p_gen;
		gen_enable == (vlcd_code != 6'h00 && !$past(supply_bypass_select));
	endproperty
	a_gen: assert property (p_gen) else $error("generator enable wrong");
	property p_nom_off;
		!gen_enable |-> vlcd_nom_mv == 13'h0000;
	endproperty
	a_nom_off: assert property (p_nom_off) else $error("supply not off");
	property p_bias;
		bias_levels == 3'h4 || bias_levels == 3'h5;
	endproperty
	a_bias: assert property (p_bias) else $error("bias level count wrong");
	property p_frame;
		frame_tick && seen |-> cnt == FRAME_DIVIDE - 1;
	endproperty
	a_frame: assert property (p_frame) else $error("frame spacing wrong");
	property p_tick;
		frame_tick |=> !frame_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("frame tick too long");
	c_tick: cover property (frame_tick && seen);
	c_icon: cover property (bias_levels == 3'h4);
	c_bypass: cover property (supply_bypass_select);
endmodule
bind lcc_host_core lcc_host_monitor #(.FRAME_DIVIDE(FRAME_DIVIDE)) mon_u (.mclk(mclk),
	.rst_n(rst_n), .bus_strobe(bus_strobe), .read_not_write(read_not_write), .db_oe(db_oe),
	.busy_flag(busy_flag), .frame_tick(frame_tick), .gen_enable(gen_enable),
	.supply_bypass_select(supply_bypass_select), .vlcd_code(vlcd_code),
	.vlcd_nom_mv(vlcd_nom_mv), .bias_levels(bias_levels));
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb import lcc_pkg::*; ();
	logic              mclk, rst_n, scan_req, scan_line, bus_strobe, register_choice_line;
	logic              read_not_write, busy_flag, frame_tick, gen_enable, supply_bypass_select;
	logic [4:0]        scan_idx;
	logic [PTR_W-1:0]  scan_addr;
	logic [DATA_W-1:0] db_in, db_out, db_oe, scan_code, st;
	logic [VREG_W-1:0] vlcd_code;
	logic [12:0]       vlcd_nom_mv;
	logic [2:0]        bias_levels;
	int                num_errors, tests_run, cyc, ticks, t0;
	logic [7:0]        tcfg [6] = '{8'h20, 8'h28, 8'h28, 8'h30, 8'h38, 8'h22};
	logic [7:0]        tsta [6] = '{8'h4E, 8'h27, 8'h67, 8'h27, 8'h4F, 8'h05};
	logic [6:0]        tend [6] = '{7'h00, 7'h40, 7'h00, 7'h00, 7'h00, 7'h04};
	int                tcnt [6] = '{2, 1, 1, 1, 1, 1};
	lcc_host_core #(.EXEC_CYCLES(20), .FRAME_DIVIDE(8)) dut_u (.mclk(mclk), .rst_n(rst_n),
		.bus_strobe(bus_strobe), .register_choice_line(register_choice_line),
		.read_not_write(read_not_write), .db_in(db_in), .db_out(db_out), .db_oe(db_oe),
		.busy_flag(busy_flag), .scan_req(scan_req), .scan_line(scan_line), .scan_idx(scan_idx),
		.scan_addr(scan_addr), .scan_code(scan_code), .frame_tick(frame_tick),
		.gen_enable(gen_enable), .supply_bypass_select(supply_bypass_select),
		.vlcd_code(vlcd_code), .vlcd_nom_mv(vlcd_nom_mv), .bias_levels(bias_levels));
	lcc_host_model host_u (.mclk(mclk), .db_out(db_out), .db_oe(db_oe), .bus_strobe(bus_strobe),
		.register_choice_line(register_choice_line), .read_not_write(read_not_write),
		.db_in(db_in));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (frame_tick === 1'b1) begin
			ticks <= ticks + 1;
		end
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic status(input logic [6:0] ptr);
		host_u.wait_idle();
		host_u.access(1'b0, 1'b1, 8'h00, st);
		chk(st, {1'b0, ptr});
	endtask
	task automatic wr(input logic [7:0] d);
		host_u.access(1'b1, 1'b0, d, st);
	endtask
	task automatic rd(input logic [7:0] exp);
		host_u.wait_idle();
		host_u.access(1'b1, 1'b1, 8'h00, st);
		chk(st, exp);
	endtask
	task automatic scan(input logic [4:0] idx, input logic [6:0] ea, input logic [7:0] ec);
		scan_idx = idx;
		scan_req = 1'b1;
		repeat (3) @(negedge mclk);
		chk(scan_addr, ea);
		chk(scan_code, ec);
		scan_req = 1'b0;
	endtask
	task automatic supply(input logic [5:0] c, input logic [12:0] mv, input logic g, input logic b);
		host_u.wait_idle();
		chk(vlcd_code, c);
		chk(vlcd_nom_mv, mv);
		chk(gen_enable, g);
		chk(supply_bypass_select, b);
	endtask
	initial begin
		rst_n = 1'b0;
		scan_req = 1'b0;
		scan_line = 1'b0;
		scan_idx = 5'h00;
		repeat (2) @(negedge mclk);
		chk(busy_flag, 1'b1);
		chk(bias_levels, BIAS_FULL);
		rst_n = 1'b1;
		supply(6'h00, 13'h0000, 1'b0, 1'b0);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			host_u.instr(tcfg[i]);
			host_u.instr(8'h80 | tsta[i]);
			for (int n = 0; n < tcnt[i]; n++) begin
				wr(tsta[i] + n[7:0]);
			end
			status(tend[i]);
		end
		host_u.instr(8'h20);
		host_u.instr(8'hCE);
		rd(8'h4E);
		rd(8'h4F);
		status(7'h00);
		host_u.instr(8'h90);
		host_u.access(1'b0, 1'b0, 8'hA0, st);
		status(7'h10);
		host_u.instr(8'h7F);
		wr(8'hA5);
		status(7'h00);
		host_u.instr(8'h7F);
		rd(8'hA5);
		$display("test address done");
		host_u.instr(8'h80);
		host_u.wait_idle();
		scan_req = 1'b1;
		wr(8'h11);
		wr(8'h22);
		wr(8'h33);
		chk(busy_flag, 1'b1);
		scan_req = 1'b0;
		status(7'h02);
		host_u.instr(8'h9F);
		wr(8'h5A);
		scan(5'h1F, 7'h1F, 8'h5A);
		scan(5'h01, 7'h01, 8'h22);
		host_u.instr(8'h18);
		scan(5'h01, 7'h00, 8'h11);
		host_u.instr(8'h28);
		host_u.instr(8'h18);
		scan_line = 1'b1;
		scan(5'h00, 7'h67, 8'h67);
		scan_line = 1'b0;
		scan(5'h01, 7'h00, 8'h11);
		host_u.instr(8'h20);
		$display("test buffer done");
		host_u.instr(8'h21);
		host_u.instr(8'h94);
		host_u.instr(8'hC5);
		supply(6'h14, 13'h0D5C, 1'b1, 1'b0);
		host_u.instr(8'h25);
		supply(6'h05, 13'h08AC, 1'b1, 1'b0);
		chk(bias_levels, BIAS_MUX2);
		host_u.instr(8'hC0);
		supply(6'h00, 13'h0000, 1'b0, 1'b0);
		host_u.instr(8'hC5);
		host_u.instr(8'h41);
		supply(6'h05, 13'h0000, 1'b0, 1'b1);
		host_u.instr(8'h40);
		host_u.instr(8'h20);
		supply(6'h14, 13'h0D5C, 1'b1, 1'b0);
		chk(bias_levels, BIAS_FULL);
		t0 = ticks;
		repeat (80) @(negedge mclk);
		chk(ticks - t0, 16'h000A);
		rst_n = 1'b0;
		repeat (2) @(negedge mclk);
		rst_n = 1'b1;
		supply(6'h00, 13'h0000, 1'b0, 1'b0);
		$display("test supply done");
		complete_run();
	end
endmodule
`default_nettype wire
